/* design/ulr_map.svh */
// register offsets, field positions and reset values of the line status block
`ifndef ULR_MAP_SVH
`define ULR_MAP_SVH
// ==========================================
// register offsets on address lines A[4:0]
`define ULR_A_DATA 5'h00
`define ULR_A_IER 5'h01
`define ULR_A_IIR 5'h02
`define ULR_A_LCR 5'h03
`define ULR_A_MCR 5'h04
`define ULR_A_LSR 5'h05
`define ULR_A_MSR 5'h06
`define ULR_A_SSR 5'h11
// ==========================================
// field positions
`define ULR_LCR_PEN 3
`define ULR_LCR_BRK 6
`define ULR_LCR_DIV 7
`define ULR_MCR_RTS 1
`define ULR_MCR_LOOP 4
`define ULR_MCR_THR 6
`define ULR_MCR_DIV4 7
`define ULR_EFR_ENH 4
`define ULR_EFR_ARTS 6
`define ULR_IER_SLEEP 4
// receive word: data 7:0, flags 10:8 (break, framing, parity), last byte 11
`define ULR_RX_W 12
`define ULR_RX_LAST 11
// ==========================================
// reset values
`define ULR_RST_LCR 8'h00
`define ULR_RST_MCR 8'h00
`define ULR_RST_IER 8'h00
`define ULR_RST_EFR 8'h00
`define ULR_RST_RD 8'h00
`endif

/* design/ulr_pkg.sv */
// types shared by the line status block
package ulr_pkg;
  typedef logic [7:0] ulr_byte_t;
  typedef logic [4:0] ulr_addr_t;
  // interrupt source codes, identification bits 5:1
  typedef enum logic [4:0] {
    ULR_IID_MODEM = 5'b00000,
    ULR_IID_THR = 5'b00001,
    ULR_IID_RHR = 5'b00010,
    ULR_IID_LINE = 5'b00011,
    ULR_IID_TMO = 5'b00110,
    ULR_IID_XOFF = 5'b01000,
    ULR_IID_FLOW = 5'b10000
  } ulr_iid_t;
  // stop length selection
  typedef enum logic [1:0] {
    ULR_STOP_1 = 2'b00,
    ULR_STOP_1_5 = 2'b01,
    ULR_STOP_2 = 2'b10
  } ulr_stop_t;
endpackage

/* design/ulr_fifo.sv */
// receive fifo with registered head word
`timescale 1ns/1ps
`default_nettype none
module ulr_fifo #(
  parameter int W = 12,
  parameter int D = 8
) (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  output var logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output var logic out_valid,
  input wire logic out_ready,
  output var logic [W-1:0] out_data,
  output var logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(D);
  // ==========================================
  // depth check
  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("ulr_fifo depth must be a power of two");
  end
  // ==========================================
  // storage and pointers
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW-1:0] rp_nxt;
  logic [AW:0] cnt_nxt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  assign cnt_nxt = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  // memory write
  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem[wp_r] <= in_data;
    end
  end
  // pointers, flags and head word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (ce) begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      rp_r <= rp_nxt;
      count <= cnt_nxt;
      in_ready <= cnt_nxt != FULL_CNT;
      out_valid <= cnt_nxt != '0;
      out_data <= (push && wp_r == rp_nxt) ? in_data : mem[rp_nxt]; // bypass into empty
    end
  end
endmodule
`default_nettype wire

/* design/ulr_regs.sv */
// line control, status, modem and interrupt registers of the serial port
`timescale 1ns/1ps
`default_nettype none
`include "ulr_map.svh"
module ulr_regs #(
  parameter int RX_DEPTH = 8
) (
  // clock, reset, freeze
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // register port
  input wire logic cs,
  input wire ulr_pkg::ulr_addr_t addr,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire ulr_pkg::ulr_byte_t wdata,
  output var ulr_pkg::ulr_byte_t rdata_r,
  // registers held outside
  output var logic ext_wr_r,
  output var ulr_pkg::ulr_addr_t ext_addr_r,
  output var ulr_pkg::ulr_byte_t ext_wdata_r,
  input wire ulr_pkg::ulr_byte_t ext_rdata,
  // mode
  input wire logic sir_mode,
  // receiver
  input wire logic rx_valid,
  output var logic rx_ready,
  input wire ulr_pkg::ulr_byte_t rx_data,
  input wire logic [2:0] rx_flags,
  input wire logic rx_last,
  input wire logic frame_too_long,
  input wire logic start_flag,
  // frame status fifo
  input wire logic [2:0] sts_head,
  input wire logic sts_empty,
  input wire logic sts_full,
  // transmitter
  output var logic tx_wr_r,
  output var ulr_pkg::ulr_byte_t tx_data_r,
  input wire logic tx_hold_empty,
  input wire logic tx_shift_empty,
  input wire logic tx_full,
  input wire logic tx_int,
  // pins
  input wire logic rx_pin,
  input wire logic cts_pin_n,
  input wire logic dsr_pin_n,
  output var logic tx_pin_r,
  output var logic rx_line_r,
  output var logic rts_pin_n_r,
  // flow and power
  input wire logic auto_rts_n,
  input wire logic wake_en,
  input wire logic module_idle,
  output var logic baud_stop_r,
  // interrupt sources
  input wire logic rx_trig,
  input wire logic rx_tmo,
  input wire logic thr_req,
  input wire logic xoff_evt,
  input wire logic flow_evt,
  input wire logic sts_trig,
  input wire logic tx_under,
  input wire logic rx_eof,
  input wire logic [1:0] fifo_mirror,
  output var logic irq_n_r,
  // format controls
  output var logic [1:0] word_len_r,
  output var ulr_pkg::ulr_stop_t stop_len_r,
  output var logic parity_en_r,
  output var logic [1:0] parity_type_r,
  output var logic break_en_r,
  output var logic div_access_r,
  output var logic loop_en_r,
  output var logic thr_access_r,
  output var logic clk_div4_r
);
  import ulr_pkg::*;
  localparam int CW = $clog2(RX_DEPTH) + 1;

  // ==========================================
  // address decode
  function automatic logic hit(input ulr_addr_t a, input ulr_addr_t off);
    hit = a == off;
  endfunction

  ulr_byte_t lcr_r;
  ulr_byte_t mcr_r;
  ulr_byte_t ier_r;
  ulr_byte_t efr_r;
  wire wr = cs && wr_stb;
  wire rd = cs && rd_stb;
  wire alt = lcr_r[`ULR_LCR_DIV];
  wire enh = efr_r[`ULR_EFR_ENH];
  wire loop = mcr_r[`ULR_MCR_LOOP];
  // alternate decode under lcr bit 7
  wire at_data = hit(addr, `ULR_A_DATA) && !alt;
  wire at_ier = hit(addr, `ULR_A_IER) && !alt;
  wire at_iir = hit(addr, `ULR_A_IIR) && !alt;
  wire at_efr = hit(addr, `ULR_A_IIR) && alt;
  wire at_lcr = hit(addr, `ULR_A_LCR);
  wire at_mcr = hit(addr, `ULR_A_MCR);
  wire at_lsr = hit(addr, `ULR_A_LSR);
  wire at_msr = hit(addr, `ULR_A_MSR) && !(enh && mcr_r[`ULR_MCR_THR]);
  wire at_ssr = hit(addr, `ULR_A_SSR);
  wire own_rd = at_data | at_ier | at_iir | at_efr | at_lcr | at_mcr | at_lsr
    | at_msr | at_ssr;
  wire own_wr = at_data | at_ier | at_efr | at_lcr | at_mcr | at_lsr | at_ssr;
  wire rd_lsr = rd && at_lsr;
  wire rd_msr = rd && at_msr;

  // ==========================================
  // receive fifo
  logic discard_r;
  logic ovr_r;
  logic last_r;
  logic [CW-1:0] err_r;
  logic f_in_ready;
  logic f_valid;
  logic [`ULR_RX_W-1:0] f_head;
  logic [CW-1:0] f_count;
  wire rx_take = rx_valid && !(sir_mode && discard_r);
  wire push = rx_take && f_in_ready;
  wire pop = rd && at_data && f_valid;
  wire [2:0] head_flg = f_valid ? f_head[10:8] : 3'b000;
  wire ovr_set = rx_take && !f_in_ready;

  ulr_fifo #(
    .W(`ULR_RX_W),
    .D(RX_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(rx_take),
    .in_ready(f_in_ready),
    .in_data({rx_last, rx_flags, rx_data}),
    .out_valid(f_valid),
    .out_ready(rd && at_data),
    .out_data(f_head),
    .count(f_count)
  );
  assign rx_ready = f_in_ready;

  // flagged character count
  wire err_inc = push && (|rx_flags);
  wire err_dec = pop && (|f_head[10:8]);
  // receive status flags, set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      discard_r <= 1'b0;
      ovr_r <= 1'b0;
      last_r <= 1'b0;
      err_r <= '0;
    end else if (ce) begin
      discard_r <= frame_too_long | (discard_r & !start_flag);
      ovr_r <= ovr_set | (ovr_r & !rd_lsr);
      last_r <= (sir_mode && pop && f_head[`ULR_RX_LAST]) | (last_r & !rd_lsr);
      err_r <= err_r + CW'(err_inc) - CW'(err_dec);
    end
  end

  // ==========================================
  // pin synchronisers and filters
  logic [2:0] s1_r;
  logic [2:0] s2_r;
  logic [2:0] s3_r;
  logic [2:0] filt_r;
  logic [2:0] filt_nxt;
  wire [2:0] pins = {dsr_pin_n, cts_pin_n, rx_pin};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    assign filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
    // three stages, change taken when stages two and three agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        s1_r[i] <= 1'b1;
        s2_r[i] <= 1'b1;
        s3_r[i] <= 1'b1;
        filt_r[i] <= 1'b1;
      end else if (ce) begin
        s1_r[i] <= pins[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        filt_r[i] <= filt_nxt[i];
      end
    end
  end
  wire [2:0] fall = filt_r & ~filt_nxt;

  // ==========================================
  // register writes with enhanced gating
  wire w_lcr = wr && at_lcr;
  wire w_mcr = wr && at_mcr;
  wire w_ier = wr && at_ier;
  wire w_efr = wr && at_efr;
  wire [7:0] mcr_keep = enh ? 8'h00 : 8'hE0;
  wire [7:0] ier_keep = (enh || sir_mode) ? 8'h00 : 8'hF0;
  wire [7:0] mcr_nxt = w_mcr ? ((wdata & ~mcr_keep) | (mcr_r & mcr_keep)) : mcr_r;
  wire [7:0] ier_nxt = w_ier ? ((wdata & ~ier_keep) | (ier_r & ier_keep)) : ier_r;
  wire cts_chg = loop ? (mcr_nxt[1] != mcr_r[1]) : (filt_nxt[1] != filt_r[1]);
  wire dsr_chg = loop ? (mcr_nxt[0] != mcr_r[0]) : (filt_nxt[2] != filt_r[2]);
  logic [1:0] msr_d_r;
  logic wake_r;
  // control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lcr_r <= `ULR_RST_LCR;
      mcr_r <= `ULR_RST_MCR;
      ier_r <= `ULR_RST_IER;
      efr_r <= `ULR_RST_EFR;
    end else if (ce) begin
      if (w_lcr) begin
        lcr_r <= wdata;
      end
      if (w_efr) begin
        efr_r <= wdata;
      end
      mcr_r <= mcr_nxt;
      ier_r <= ier_nxt;
    end
  end
  // modem change and wake flags, set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      msr_d_r <= 2'b00;
      wake_r <= 1'b0;
    end else if (ce) begin
      msr_d_r <= {dsr_chg, cts_chg} | (msr_d_r & {2{!rd_msr}});
      wake_r <= (wake_en && (|fall)) | (wake_r & wake_en);
    end
  end

  // ==========================================
  // interrupt sources and priority
  wire uart = !sir_mode;
  wire src_line = uart && ier_r[2] && (ovr_r || (|head_flg));
  wire src_tmo = uart && ier_r[0] && rx_tmo;
  wire src_rhr = uart && ier_r[0] && rx_trig;
  wire src_thr = uart && ier_r[1] && thr_req;
  wire src_mdm = uart && ier_r[3] && (|msr_d_r);
  wire src_xoff = uart && ier_r[5] && xoff_evt;
  wire src_flow = uart && (ier_r[6] || ier_r[7]) && flow_evt;
  wire pend = src_line | src_tmo | src_rhr | src_thr | src_mdm | src_xoff | src_flow;
  // highest pending source wins
  wire ulr_iid_t iid = src_line ? ULR_IID_LINE :
    src_tmo ? ULR_IID_TMO :
    src_rhr ? ULR_IID_RHR :
    src_thr ? ULR_IID_THR :
    src_mdm ? ULR_IID_MODEM :
    src_xoff ? ULR_IID_XOFF :
    src_flow ? ULR_IID_FLOW : ULR_IID_MODEM;
  // infrared sources, bit 0 to 7
  wire sts_err = !sts_empty && (|sts_head);
  wire [7:0] sir_src = ier_r & {rx_eof, sts_err, tx_under, sts_trig, ovr_r, last_r,
    thr_req, rx_trig};

  // ==========================================
  // read data selection
  wire tx_all_empty = tx_hold_empty && tx_shift_empty;
  wire rx_fifo_any_error = err_r != '0;
  wire [7:0] lsr_uart = {rx_fifo_any_error, tx_all_empty, tx_hold_empty, head_flg,
    ovr_r, f_valid};
  wire [2:0] sts_flg = sts_empty ? 3'b000 : sts_head;
  wire [7:0] lsr_sir = {tx_hold_empty, sts_full, last_r, sts_flg, sts_empty,
    !f_valid};
  wire [1:0] live = loop ? {mcr_r[0], mcr_r[1]} : ~filt_r[2:1];
  wire [7:0] msr_rd = {2'b00, live, 2'b00, msr_d_r};
  wire [7:0] iir_rd = sir_mode ? sir_src : {fifo_mirror, iid, !pend};
  wire [7:0] lsr_rd = sir_mode ? lsr_sir : lsr_uart;
  wire [7:0] rd_mux = !own_rd ? ext_rdata :
    at_data ? f_head[7:0] :
    at_ier ? ier_r :
    at_iir ? iir_rd :
    at_efr ? efr_r :
    at_lcr ? lcr_r :
    at_mcr ? mcr_r :
    at_lsr ? lsr_rd :
    at_msr ? msr_rd : {6'h00, wake_r, tx_full};
  wire ulr_stop_t stop_nxt = !lcr_r[2] ? ULR_STOP_1 :
    (lcr_r[1:0] == 2'b00) ? ULR_STOP_1_5 : ULR_STOP_2;

  // ==========================================
  // read data, forwarded and transmit strobes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= `ULR_RST_RD;
      ext_wr_r <= 1'b0;
      ext_addr_r <= '0;
      ext_wdata_r <= '0;
      tx_wr_r <= 1'b0;
      tx_data_r <= '0;
    end else if (ce) begin
      if (rd) begin
        rdata_r <= rd_mux;
      end
      ext_wr_r <= wr && !own_wr;
      ext_addr_r <= addr;
      ext_wdata_r <= wdata;
      tx_wr_r <= wr && at_data && !tx_full;
      if (wr && at_data) begin
        tx_data_r <= wdata;
      end
    end
  end
  // pins, interrupt line and format outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin_r <= 1'b1;
      rx_line_r <= 1'b1;
      rts_pin_n_r <= 1'b1;
      baud_stop_r <= 1'b0;
      irq_n_r <= 1'b1;
      stop_len_r <= ULR_STOP_1;
    end else if (ce) begin
      tx_pin_r <= loop ? 1'b1 : tx_int;
      rx_line_r <= loop ? tx_int : filt_r[0];
      rts_pin_n_r <= efr_r[`ULR_EFR_ARTS] ? auto_rts_n : !mcr_r[`ULR_MCR_RTS];
      baud_stop_r <= uart && ier_r[`ULR_IER_SLEEP] && module_idle;
      irq_n_r <= sir_mode ? !(|sir_src) : !pend;
      stop_len_r <= stop_nxt;
    end
  end
  // format fields straight from the control registers
  assign word_len_r = lcr_r[1:0];
  assign parity_en_r = lcr_r[`ULR_LCR_PEN];
  assign parity_type_r = lcr_r[5:4];
  assign break_en_r = lcr_r[`ULR_LCR_BRK];
  assign div_access_r = lcr_r[`ULR_LCR_DIV];
  assign loop_en_r = mcr_r[`ULR_MCR_LOOP];
  assign thr_access_r = mcr_r[`ULR_MCR_THR];
  assign clk_div4_r = mcr_r[`ULR_MCR_DIV4];

  // ==========================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence s_lsr_rd;
    ce && rd_lsr;
  endsequence
  sequence s_last_pop;
    ce && sir_mode && pop && f_head[`ULR_RX_LAST];
  endsequence
  ovr_set_a: assert property (ce && ovr_set |=> ovr_r)
    else $error("overrun not flagged");
  lsr_empty_a: assert property ((s_lsr_rd and uart) |=> rdata_r[0] == $past(f_valid))
    else $error("receive level bit wrong");
  lsr_nopop_a: assert property ((s_lsr_rd and !rx_take) |=> f_count == $past(f_count))
    else $error("status read moved the fifo");
  err_any_a: assert property (!f_valid |-> err_r == '0)
    else $error("flagged count left with empty fifo");
  last_set_a: assert property (s_last_pop |=> last_r)
    else $error("last byte flag missed");
  last_clr_a: assert property ((s_lsr_rd and !pop) |=> !last_r)
    else $error("last byte flag kept after read");
  rts_drive_a: assert property (ce && !efr_r[6] && mcr_r[1] |=> !rts_pin_n_r)
    else $error("rts not driven active");
  loop_route_a: assert property (ce && loop |=> rx_line_r == $past(tx_int))
    else $error("loop path broken");
  mcr_gate_a: assert property (ce && w_mcr && !enh |=> $stable(mcr_r[7:5]))
    else $error("protected modem bits written");
  ier_gate_a: assert property (ce && w_ier && !enh && uart |=> $stable(ier_r[7:4]))
    else $error("protected enable bits written");
  irq_pend_a: assert property (ce && uart && pend |=> !irq_n_r)
    else $error("interrupt line not asserted");
  iid_prio_a: assert property (ce && rd && at_iir && src_line && uart
    |=> rdata_r[5:0] == {ULR_IID_LINE, 1'b0})
    else $error("line status not top priority");
endmodule
`default_nettype wire

/* bench/ulr_peer.sv */
// remote serial device model: offers received characters and drives the modem pins
`timescale 1ns/1ps
`default_nettype none
module ulr_peer (
  // clock
  input wire logic clk_sys,
  // character side
  output var logic rx_valid,
  output var ulr_pkg::ulr_byte_t rx_data,
  output var logic [2:0] rx_flags,
  output var logic rx_last,
  // modem pins, idle high
  output var logic rx_pin,
  output var logic cts_pin_n,
  output var logic dsr_pin_n
);
  import ulr_pkg::*;
  // ==========================================
  // idle state: nothing offered, pins inactive
  initial begin
    {rx_valid, rx_data, rx_flags, rx_last} = '0;
    {rx_pin, cts_pin_n, dsr_pin_n} = 3'b111;
  end
  // one character per call, offered at exactly one taking edge; the gap
  // gives both prompt and slow arrival
  task automatic send(input ulr_byte_t dt, input logic [2:0] fl, input logic lst,
                      input int gap);
    @(posedge clk_sys);
    rx_valid <= 1'b1;
    rx_data <= dt;
    rx_flags <= fl;
    rx_last <= lst;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
    // released lines carry garbage, never the last value
    rx_data <= ~dt;
    rx_flags <= ~fl;
    rx_last <= ~lst;
    repeat (gap) @(posedge clk_sys);
  endtask
  // modem line levels, changed just after an edge
  task automatic set_modem(input logic cts_n, input logic dsr_n);
    @(posedge clk_sys);
    cts_pin_n <= cts_n;
    dsr_pin_n <= dsr_n;
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench of the serial port line status and interrupt registers
`timescale 1ns/1ps
`default_nettype none
`include "ulr_map.svh"
module tb_top;
  import ulr_pkg::*;
  // ==========================================
  // design inputs and outputs
  logic clk_sys, rst_n, ce, cs, wr_stb, rd_stb, sir_mode, frame_too_long, start_flag;
  logic sts_empty, sts_full, tx_hold_empty, tx_shift_empty, tx_full, tx_int, auto_rts_n;
  logic wake_en, module_idle, rx_trig, rx_tmo, thr_req, xoff_evt, flow_evt, sts_trig;
  logic tx_under, rx_eof, rx_valid, rx_last, rx_pin, cts_pin_n, dsr_pin_n;
  logic [1:0] fifo_mirror, word_len_r, parity_type_r, wpulse;
  logic [2:0] sts_head, rx_flags, f;
  ulr_addr_t addr, ext_addr_r;
  ulr_byte_t wdata, ext_rdata, rx_data, rdata_r, ext_wdata_r, tx_data_r, rd, d, r, v;
  ulr_stop_t stop_len_r;
  logic ext_wr_r, rx_ready, tx_wr_r, tx_pin_r, rx_line_r, rts_pin_n_r, baud_stop_r, irq_n_r;
  logic parity_en_r, break_en_r, div_access_r, loop_en_r, thr_access_r, clk_div4_r;
  // ==========================================
  // bench state
  int tests_run = 0;
  int miscompares = 0;
  logic [31:0] seed = 32'h2D9C;
  logic [10:0] q[$];
  logic [10:0] e;
  // divisor low byte for 115200 baud from the 200 MHz clock
  localparam int div_val = 200_000_000 / (16 * 115_200);

  ulr_regs #(.RX_DEPTH(8)) ulr_regs_inst (.*);
  ulr_peer ulr_peer_inst (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_flags(rx_flags), .rx_last(rx_last), .rx_pin(rx_pin), .cts_pin_n(cts_pin_n),
    .dsr_pin_n(dsr_pin_n));
  // ==========================================
  // helpers
  function automatic ulr_byte_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic ulr_stop_t stop_of(input ulr_byte_t lc);
    if (!lc[2]) return ULR_STOP_1;
    return (lc[1:0] == 2'b00) ? ULR_STOP_1_5 : ULR_STOP_2;
  endfunction
  // serial line status from the bench copy of the receive fifo
  function automatic ulr_byte_t lsr_ser(input logic ovr);
    logic bad;
    bad = 1'b0;
    foreach (q[k]) bad |= (q[k][10:8] != 3'b000);
    return {bad, tx_hold_empty & tx_shift_empty, tx_hold_empty,
            (q.size() > 0) ? q[0][10:8] : 3'b000, ovr, q.size() > 0};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle: strobe held for one taking edge, results read after it
  task automatic xfer(input logic w, input ulr_addr_t a, input ulr_byte_t dt);
    @(posedge clk_sys);
    cs <= 1'b1;
    wr_stb <= w;
    rd_stb <= !w;
    addr <= a;
    wdata <= dt;
    @(posedge clk_sys);
    cs <= 1'b0;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    #1;
    rd = rdata_r;
    wpulse = {ext_wr_r, tx_wr_r};
  endtask
  task automatic rdc(input ulr_addr_t a, input ulr_byte_t exp);
    xfer(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  task automatic iir_is(input logic [5:0] code);
    repeat (4) @(posedge clk_sys);
    rdc(`ULR_A_IIR, {fifo_mirror, code});
    chk(irq_n_r, code[0]);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #50000;
    miscompares++;
    stop_test();
  end
  // ==========================================
  // main sequence
  initial begin
    {cs, wr_stb, rd_stb, sir_mode, frame_too_long, start_flag, sts_full, tx_full} = '0;
    {tx_int, rx_trig, rx_tmo, thr_req, xoff_evt, flow_evt, sts_trig, tx_under} = '0;
    {rx_eof, wake_en, module_idle, sts_empty, sts_head, fifo_mirror, addr, wdata} = '0;
    {ce, tx_hold_empty, tx_shift_empty, auto_rts_n} = '1;
    ext_rdata = rnd();
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values
    rdc(`ULR_A_LCR, 8'h00);
    rdc(`ULR_A_IER, 8'h00);
    rdc(`ULR_A_MCR, 8'h00);
    rdc(`ULR_A_LSR, 8'h60);
    rdc(`ULR_A_IIR, 8'h01);
    rdc(`ULR_A_SSR, 8'h00);
    // every length, stop and parity code
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      v = {1'b0, r[6], i[3:2], r[3], i[4], i[1:0]};
      xfer(1'b1, `ULR_A_LCR, v);
      rdc(`ULR_A_LCR, v);
      chk(word_len_r, v[1:0]);
      chk(stop_len_r, stop_of(v));
      chk({parity_en_r, parity_type_r, break_en_r}, {v[3], v[5:4], v[6]});
    end
    // alternate decode forwards offset zero
    xfer(1'b1, `ULR_A_LCR, 8'h83);
    chk(div_access_r, 1'b1);
    xfer(1'b1, `ULR_A_DATA, 8'(div_val));
    chk(wpulse, 2'b10);
    chk(ext_wdata_r, 8'(div_val));
    chk(ext_addr_r, `ULR_A_DATA);
    rdc(`ULR_A_DATA, ext_rdata);
    xfer(1'b1, `ULR_A_LCR, 8'h03);
    // protected bits with enhanced enable clear, then loop-back
    xfer(1'b1, `ULR_A_MCR, 8'hFF);
    rdc(`ULR_A_MCR, 8'h1F);
    chk({loop_en_r, tx_pin_r, rx_line_r}, 3'b110);
    xfer(1'b0, `ULR_A_MSR, 8'h00);
    chk(rd & 8'h30, 8'h30);
    xfer(1'b1, `ULR_A_IER, 8'hFF);
    rdc(`ULR_A_IER, 8'h0F);
    xfer(1'b1, `ULR_A_MCR, 8'h02);
    @(posedge clk_sys);
    #1 chk(rts_pin_n_r, 1'b0);
    xfer(1'b1, `ULR_A_MCR, 8'h00);
    @(posedge clk_sys);
    #1 chk({rts_pin_n_r, tx_pin_r, rx_line_r}, 3'b101);
    // enhanced enable opens the protected bits
    xfer(1'b1, `ULR_A_LCR, 8'h80);
    xfer(1'b1, `ULR_A_IIR, 8'h10);
    xfer(1'b1, `ULR_A_LCR, 8'h03);
    xfer(1'b1, `ULR_A_MCR, 8'hE0);
    rdc(`ULR_A_MCR, 8'hE0);
    chk({clk_div4_r, thr_access_r}, 2'b11);
    xfer(1'b1, `ULR_A_MCR, 8'h00);
    xfer(1'b1, `ULR_A_IER, 8'h10);
    rdc(`ULR_A_IER, 8'h10);
    module_idle <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk(baud_stop_r, 1'b1);
    module_idle <= 1'b0;
    // transmit writes, refused when full
    xfer(1'b1, `ULR_A_DATA, 8'hC3);
    chk(wpulse, 2'b01);
    chk(tx_data_r, 8'hC3);
    tx_full <= 1'b1;
    xfer(1'b1, `ULR_A_DATA, 8'h3C);
    chk(wpulse, 2'b00);
    rdc(`ULR_A_SSR, 8'h01);
    tx_full <= 1'b0;
    // fill receive fifo past full, then drain
    for (int i = 0; i < 9; i++) begin
      r = rnd();
      d = rnd();
      f = r[2:0] & {3{r[3]}};
      if (i < 8) q.push_back({f, d});
      ulr_peer_inst.send(d, f, 1'b0, int'(r[5:4]));
    end
    repeat (2) @(posedge clk_sys);
    #1 chk(rx_ready, 1'b0);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      {tx_hold_empty, tx_shift_empty} <= r[1:0];
      xfer(1'b0, `ULR_A_LSR, 8'h00);
      chk(rd, lsr_ser(i == 0));
      e = q.pop_front();
      rdc(`ULR_A_DATA, e[7:0]);
    end
    xfer(1'b0, `ULR_A_LSR, 8'h00);
    chk(rd & 8'hE3, lsr_ser(1'b0) & 8'hE3);
    // interrupt priority walk down every source code
    xfer(1'b1, `ULR_A_IER, 8'hEF);
    xfer(1'b0, `ULR_A_MSR, 8'h00);
    r = rnd();
    fifo_mirror <= r[1:0];
    {sts_trig, tx_under, rx_eof} <= r[4:2];
    {rx_trig, thr_req, xoff_evt, flow_evt} <= 4'hF;
    wake_en <= 1'b1;
    ulr_peer_inst.set_modem(1'b0, 1'b1);
    ulr_peer_inst.send(d, 3'b100, 1'b0, 0);
    iir_is(6'b000110);
    rdc(`ULR_A_DATA, d);
    iir_is(6'b000100);
    rx_trig <= 1'b0;
    rx_tmo <= 1'b1;
    iir_is(6'b001100);
    rx_tmo <= 1'b0;
    iir_is(6'b000010);
    thr_req <= 1'b0;
    iir_is(6'b000000);
    rdc(`ULR_A_MSR, 8'h11);
    rdc(`ULR_A_MSR, 8'h10);
    iir_is(6'b010000);
    xoff_evt <= 1'b0;
    iir_is(6'b100000);
    flow_evt <= 1'b0;
    iir_is(6'b000001);
    rdc(`ULR_A_SSR, 8'h02);
    wake_en <= 1'b0;
    rdc(`ULR_A_SSR, 8'h00);
    // infrared status, too-long frame and last byte
    xfer(1'b1, `ULR_A_IER, 8'h00);
    sir_mode <= 1'b1;
    r = rnd();
    {sts_head, sts_empty, sts_full} <= r[4:0];
    xfer(1'b0, `ULR_A_LSR, 8'h00);
    v = {tx_hold_empty, sts_full, 1'b0, sts_empty ? 3'b000 : sts_head, sts_empty, 1'b1};
    chk(rd, v);
    // infrared enables: source bits 4 to 7 show in the identification read
    rx_eof <= 1'b1;
    xfer(1'b1, `ULR_A_IER, 8'hFF);
    v = {1'b1, !sts_empty && (|sts_head), tx_under, sts_trig, 4'h0};
    rdc(`ULR_A_IIR, v);
    chk(irq_n_r, v == 8'h00);
    @(posedge clk_sys);
    frame_too_long <= 1'b1;
    @(posedge clk_sys);
    frame_too_long <= 1'b0;
    ulr_peer_inst.send(8'hA5, 3'b000, 1'b0, 1);
    xfer(1'b0, `ULR_A_LSR, 8'h00);
    chk(rd[0], 1'b1);
    @(posedge clk_sys);
    start_flag <= 1'b1;
    @(posedge clk_sys);
    start_flag <= 1'b0;
    ulr_peer_inst.send(d, 3'b000, 1'b1, 1);
    rdc(`ULR_A_DATA, d);
    xfer(1'b0, `ULR_A_LSR, 8'h00);
    chk({rd[5], rd[0]}, 2'b11);
    xfer(1'b0, `ULR_A_LSR, 8'h00);
    chk(rd[5], 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
